/* ccs_pkg.sv */
// constants, types and helpers for the capture and configuration store registers
// Operation
// - format 0 or 7: continuous bit starts/stops
// - save bit copies working set to channel
// - save bit clears itself after saving
// - format 0 or 7: single request sends one frame
// - single request clears after frame sent
// - repeat bit and count have no effect
// - load write 0..3 copies channel to working
// - load register reads last loaded channel
// - format held in format register bits 0..2
package ccs_pkg;

    // ****************************************
    // bus geometry and register offsets
    // ****************************************
    localparam int REG_AW = 12;
    localparam int REG_DW = 32;
    localparam logic [REG_AW-1:0] OFF_MODE = 12'h604;
    localparam logic [REG_AW-1:0] OFF_FORMAT = 12'h608;
    localparam logic [REG_AW-1:0] OFF_CONT = 12'h614;
    localparam logic [REG_AW-1:0] OFF_SAVE = 12'h618;
    localparam logic [REG_AW-1:0] OFF_SHOT = 12'h61c;
    localparam logic [REG_AW-1:0] OFF_SAVE_CH = 12'h620;
    localparam logic [REG_AW-1:0] OFF_LOAD_CH = 12'h624;
    localparam logic [REG_AW-1:0] OFF_STATUS = 12'h640;

    // ****************************************
    // field positions
    // ****************************************
    localparam int FLD_W = 3;
    localparam int CH_W = 2;
    localparam int BIT_GO = 0;
    localparam int ST_BUSY = 0;
    localparam int ST_SHOT = 1;
    localparam int ST_FMT_OK = 2;
    localparam int ST_CNT_LSB = 4;

    // ****************************************
    // reset values and legal codes
    // ****************************************
    localparam logic [FLD_W-1:0] RST_MODE = 3'h0;
    localparam logic [FLD_W-1:0] RST_FORMAT = 3'h7;
    localparam logic [CH_W-1:0] RST_SAVE_CH = 2'h1;
    localparam logic [CH_W-1:0] RST_LOAD_CH = 2'h0;
    localparam logic [FLD_W-1:0] FMT_STD = 3'h0;
    localparam logic [FLD_W-1:0] FMT_SCAL = 3'h7;
    localparam logic [CH_W-1:0] CH_SAVE_MIN = 2'h1;
    localparam int NUM_CH = 4;

    // ****************************************
    // stream and buffer sizes
    // ****************************************
    localparam int PIX_W = 32;
    localparam int FIFO_DEPTH = 8;

    typedef struct packed {
        logic [FLD_W-1:0] mode;
        logic [FLD_W-1:0] format;
    } ccs_cfg_s;

    localparam ccs_cfg_s CFG_DEFAULT = '{mode: RST_MODE, format: RST_FORMAT};

    typedef enum logic [1:0] {
        GATE_IDLE = 2'b00,
        GATE_PASS = 2'b01,
        GATE_DROP = 2'b10
    } ccs_gate_e;

    // frame transfer allowed only in these formats
    function automatic logic ccs_fmt_ok(input logic [FLD_W-1:0] fmt);
        return (fmt == FMT_STD) || (fmt == FMT_SCAL);
    endfunction

    // channel value fits and is at least lo
    function automatic logic ccs_ch_ok(input logic [REG_DW-1:0] v, input logic [CH_W-1:0] lo);
        return (v[REG_DW-1:CH_W] == '0) && (v[CH_W-1:0] >= lo);
    endfunction

endpackage

/* ccs_strm_if.sv */
// valid/ready stream carrier between the register block and its buffer
`timescale 1ns/1ns
`default_nettype none
interface ccs_strm_if #(parameter int W = 34);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* ccs_fifo.sv */
// flip-flop fifo with valid/ready on both sides
`timescale 1ns/1ns
`default_nettype none
module ccs_fifo #(
    parameter int W = 34,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    ccs_strm_if.snk wr,
    ccs_strm_if.src rd,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH) $error("ccs_fifo: DEPTH must be a power of two");
    end

    logic [W-1:0] mem_r [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic full;
    logic empty;

    assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign empty = (wp_r == rp_r);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data = mem_r[rp_r[AW-1:0]];
    assign level = wp_r - rp_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
        end else if (wr.valid && !full) begin
            wp_r <= wp_r + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (wr.valid && !full) begin
            mem_r[wp_r[AW-1:0]] <= wr.data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rp_r <= '0;
        end else if (rd.ready && !empty) begin
            rp_r <= rp_r + 1'b1;
        end
    end
endmodule // ccs_fifo
`default_nettype wire

/* ccs_cfg_store.sv */
// numbered configuration channels; channel 0 holds the fixed defaults
`timescale 1ns/1ns
`default_nettype none
module ccs_cfg_store
    import ccs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic save_req,
    input wire logic [ccs_pkg::CH_W-1:0] save_ch,
    input wire ccs_pkg::ccs_cfg_s save_cfg,
    input wire logic [ccs_pkg::CH_W-1:0] load_ch,
    output ccs_pkg::ccs_cfg_s load_cfg
);
    ccs_cfg_s chan_r [NUM_CH];

    // channel 0 is never written
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CH; i++) begin
                chan_r[i] <= CFG_DEFAULT;
            end
        end else if (save_req && save_ch != '0) begin
            chan_r[save_ch] <= save_cfg;
        end
    end

    assign load_cfg = (load_ch == '0) ? CFG_DEFAULT : chan_r[load_ch];
endmodule // ccs_cfg_store
`default_nettype wire

/* ccs_regs_top.sv */
// transmission control and configuration channel registers with frame gate
`timescale 1ns/1ns
`default_nettype none
module ccs_regs_top
    import ccs_pkg::*;
#(
    parameter int DEPTH = ccs_pkg::FIFO_DEPTH
) (
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [ccs_pkg::REG_AW-1:0] REG_ADDR,
    input wire logic [ccs_pkg::REG_DW-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [ccs_pkg::REG_DW-1:0] REG_RDATA,
    input wire logic [ccs_pkg::PIX_W-1:0] PIX_DATA,
    input wire logic PIX_LAST,
    input wire logic PIX_VALID,
    output logic PIX_READY,
    output logic [ccs_pkg::PIX_W-1:0] TX_DATA,
    output logic TX_LAST,
    output logic TX_VALID,
    input wire logic TX_READY,
    output logic CAPTURE_EN,
    output logic [ccs_pkg::FLD_W-1:0] VIDEO_FORMAT,
    output logic [ccs_pkg::FLD_W-1:0] VIDEO_MODE
);
    import ccs_pkg::*;

    localparam int FW = PIX_W + 2;
    localparam int LW = $clog2(DEPTH) + 1;
    initial begin
        if (DEPTH > 8 || DEPTH < 2) $error("ccs_regs_top: DEPTH out of range");
    end

    // ****************************************
    // state
    // ****************************************
    ccs_cfg_s work_r;
    logic cont_r;
    logic shot_r;
    logic shot_started_r;
    logic save_pend_r;
    logic [CH_W-1:0] save_ch_r;
    logic [CH_W-1:0] load_ch_r;
    ccs_gate_e gate_r;
    ccs_gate_e gate_nxt;
    logic cap_en_r;
    logic [REG_DW-1:0] rdata_r;
    logic [REG_DW-1:0] rdata_nxt;

    ccs_cfg_s load_cfg;
    logic [LW-1:0] fifo_level;
    logic fmt_ok;
    logic want_frame;
    logic tag_new;
    logic pass_now;
    logic pix_take;
    logic tx_take;
    logic shot_done;
    logic shot_set;
    logic wr_mode;
    logic wr_format;
    logic wr_cont;
    logic wr_save;
    logic wr_shot;
    logic wr_save_ch;
    logic wr_load_ch;

    ccs_strm_if #(.W(FW)) fin ();
    ccs_strm_if #(.W(FW)) fout ();

    // ****************************************
    // write decode
    // ****************************************
    assign wr_mode = REG_WR && (REG_ADDR == OFF_MODE);
    assign wr_format = REG_WR && (REG_ADDR == OFF_FORMAT);
    assign wr_cont = REG_WR && (REG_ADDR == OFF_CONT);
    assign wr_save = REG_WR && (REG_ADDR == OFF_SAVE);
    assign wr_shot = REG_WR && (REG_ADDR == OFF_SHOT);
    assign wr_save_ch = REG_WR && (REG_ADDR == OFF_SAVE_CH);
    assign wr_load_ch = REG_WR && (REG_ADDR == OFF_LOAD_CH);

    assign fmt_ok = ccs_fmt_ok(work_r.format);

    // ****************************************
    // working configuration set
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            work_r <= CFG_DEFAULT;
        end else if (wr_load_ch && ccs_ch_ok(REG_WDATA, '0)) begin
            work_r <= load_cfg;
        end else if (wr_format) begin
            work_r.format <= REG_WDATA[FLD_W-1:0];
        end else if (wr_mode) begin
            work_r.mode <= REG_WDATA[FLD_W-1:0];
        end
    end

    // ****************************************
    // channel registers
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            save_ch_r <= RST_SAVE_CH;
        end else if (wr_save_ch && ccs_ch_ok(REG_WDATA, CH_SAVE_MIN)) begin
            save_ch_r <= REG_WDATA[CH_W-1:0];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            load_ch_r <= RST_LOAD_CH;
        end else if (wr_load_ch && ccs_ch_ok(REG_WDATA, '0)) begin
            load_ch_r <= REG_WDATA[CH_W-1:0];
        end
    end

    // save runs one cycle after the request, then the bit drops
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            save_pend_r <= 1'b0;
        end else if (wr_save && REG_WDATA[BIT_GO]) begin
            save_pend_r <= 1'b1;
        end else begin
            save_pend_r <= 1'b0;
        end
    end

    ccs_cfg_store u_store (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .save_req(save_pend_r),
        .save_ch(save_ch_r),
        .save_cfg(work_r),
        .load_ch(REG_WDATA[CH_W-1:0]),
        .load_cfg(load_cfg)
    );

    // ****************************************
    // transmission control bits
    // ****************************************
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cont_r <= 1'b0;
        end else if (wr_cont && !REG_WDATA[BIT_GO]) begin
            cont_r <= 1'b0;
        end else if (wr_cont && fmt_ok) begin
            cont_r <= 1'b1;
        end
    end

    // repeat bit and count field are not looked at
    assign shot_set = wr_shot && REG_WDATA[BIT_GO] && fmt_ok;
    assign shot_done = tx_take && fout.data[PIX_W] && fout.data[PIX_W+1];

    // a new request in the finishing cycle survives
    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            shot_r <= 1'b0;
        end else begin
            shot_r <= shot_set || (shot_r && !shot_done);
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            shot_started_r <= 1'b0;
        end else if (shot_done) begin
            shot_started_r <= 1'b0;
        end else if (pix_take && gate_r == GATE_IDLE && pass_now && tag_new) begin
            shot_started_r <= 1'b1;
        end
    end

    // ****************************************
    // frame gate
    // ****************************************
    assign tag_new = shot_r && !shot_started_r;
    assign want_frame = fmt_ok && (cont_r || tag_new);
    assign pass_now = (gate_r == GATE_PASS) || (gate_r == GATE_IDLE && want_frame);
    assign PIX_READY = pass_now ? fin.ready : 1'b1;
    assign pix_take = PIX_VALID && PIX_READY;
    assign fin.valid = PIX_VALID && pass_now;
    assign fin.data = {(gate_r == GATE_IDLE) ? tag_new : shot_started_r, PIX_LAST, PIX_DATA};

    always_comb begin
        gate_nxt = gate_r;
        if (pix_take) begin
            if (PIX_LAST) begin
                gate_nxt = GATE_IDLE;
            end else if (gate_r == GATE_IDLE) begin
                gate_nxt = pass_now ? GATE_PASS : GATE_DROP;
            end
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            gate_r <= GATE_IDLE;
        end else begin
            gate_r <= gate_nxt;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cap_en_r <= 1'b0;
        end else begin
            cap_en_r <= want_frame || (gate_nxt == GATE_PASS);
        end
    end

    ccs_fifo #(.W(FW), .DEPTH(DEPTH)) u_fifo (
        .clk(CORE_CLK),
        .rst_n(RST_N),
        .wr(fin),
        .rd(fout),
        .level(fifo_level)
    );

    assign fout.ready = TX_READY;
    assign tx_take = fout.valid && TX_READY;
    assign TX_VALID = fout.valid;
    assign TX_DATA = fout.data[PIX_W-1:0];
    assign TX_LAST = fout.data[PIX_W];
    assign CAPTURE_EN = cap_en_r;
    assign VIDEO_FORMAT = work_r.format;
    assign VIDEO_MODE = work_r.mode;

    // ****************************************
    // read path
    // ****************************************
    always_comb begin
        rdata_nxt = '0;
        if (REG_RD) begin
            unique case (REG_ADDR)
                OFF_MODE: rdata_nxt[FLD_W-1:0] = work_r.mode;
                OFF_FORMAT: rdata_nxt[FLD_W-1:0] = work_r.format;
                OFF_CONT: rdata_nxt[BIT_GO] = cont_r;
                OFF_SAVE: rdata_nxt[BIT_GO] = save_pend_r;
                OFF_SHOT: rdata_nxt[BIT_GO] = shot_r;
                OFF_SAVE_CH: rdata_nxt[CH_W-1:0] = save_ch_r;
                OFF_LOAD_CH: rdata_nxt[CH_W-1:0] = load_ch_r;
                OFF_STATUS: begin
                    rdata_nxt[ST_BUSY] = (gate_r != GATE_IDLE);
                    rdata_nxt[ST_SHOT] = shot_started_r;
                    rdata_nxt[ST_FMT_OK] = fmt_ok;
                    rdata_nxt[ST_CNT_LSB +: LW] = fifo_level;
                end
                default: rdata_nxt = '0;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign REG_RDATA = rdata_r;
endmodule // ccs_regs_top
`default_nettype wire

/* ccs_regs_chk.sv */
// port assertions for the capture and config store registers
`timescale 1ns/1ns
`default_nettype none
module ccs_regs_chk
    import ccs_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_N,
    input wire logic [ccs_pkg::REG_AW-1:0] REG_ADDR,
    input wire logic [ccs_pkg::REG_DW-1:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [ccs_pkg::REG_DW-1:0] REG_RDATA,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic TX_LAST,
    input wire logic CAPTURE_EN,
    input wire logic [ccs_pkg::FLD_W-1:0] VIDEO_FORMAT,
    input wire logic [ccs_pkg::FLD_W-1:0] VIDEO_MODE
);
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    logic fok;
    logic ld;
    logic sv;
    logic [2:0] wlo;
    assign fok = (VIDEO_FORMAT == FMT_STD) || (VIDEO_FORMAT == FMT_SCAL);
    assign ld = REG_WR && (REG_ADDR == OFF_LOAD_CH);
    assign sv = REG_WR && (REG_ADDR == OFF_SAVE) && REG_WDATA[0];
    assign wlo = REG_WDATA[2:0];
    property p_rd_idle;
        !$past(REG_RD) |-> REG_RDATA == 32'h0;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_go;
        REG_WR && (REG_ADDR == OFF_CONT || REG_ADDR == OFF_SHOT) && REG_WDATA[0] && fok
            |-> ##2 CAPTURE_EN;
    endproperty
    a_go: assert property (p_go) else $error("capture not enabled");
    property p_blk;
        REG_WR && REG_ADDR == OFF_SHOT && !fok && !CAPTURE_EN |=> !CAPTURE_EN;
    endproperty
    a_blk: assert property (p_blk) else $error("capture in wrong format");
    property p_fmt;
        REG_WR && REG_ADDR == OFF_FORMAT |=> VIDEO_FORMAT == $past(wlo);
    endproperty
    a_fmt: assert property (p_fmt) else $error("format not taken");
    property p_ld0;
        ld && REG_WDATA == 32'h0 |=> VIDEO_FORMAT == RST_FORMAT && VIDEO_MODE == RST_MODE;
    endproperty
    a_ld0: assert property (p_ld0) else $error("channel 0 not loaded");
    property p_ldbad;
        ld && REG_WDATA > 32'h3 |=> $stable(VIDEO_FORMAT) && $stable(VIDEO_MODE);
    endproperty
    a_ldbad: assert property (p_ldbad) else $error("bad load changed set");
    property p_ldrd;
        ld && REG_WDATA <= 32'h3 ##1 REG_RD && REG_ADDR == OFF_LOAD_CH
            |=> REG_RDATA == $past(REG_WDATA, 2);
    endproperty
    a_ldrd: assert property (p_ldrd) else $error("load channel readback");
    property p_svpend;
        sv ##1 REG_RD && REG_ADDR == OFF_SAVE |=> REG_RDATA == 32'h1;
    endproperty
    a_svpend: assert property (p_svpend) else $error("save not pending");
    property p_svclr;
        REG_RD && REG_ADDR == OFF_SAVE && !$past(sv) |=> REG_RDATA == 32'h0;
    endproperty
    a_svclr: assert property (p_svclr) else $error("save bit stuck");
    c_save: cover property (sv);
    c_load: cover property (ld);
    c_last: cover property (TX_VALID && TX_READY && TX_LAST);
endmodule // ccs_regs_chk
bind ccs_regs_top ccs_regs_chk u_chk (.CORE_CLK, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR,
    .REG_RD, .REG_RDATA, .TX_VALID, .TX_READY, .TX_LAST, .CAPTURE_EN, .VIDEO_FORMAT,
    .VIDEO_MODE);
`default_nettype wire

/* ccs_pix_model.sv */
// frame source and stalling sink around the register block
`timescale 1ns/1ns
`default_nettype none
module ccs_pix_model
    import ccs_pkg::*;
#(
    parameter int FLEN = 12
) (
    input wire logic clk,
    input wire logic start,
    input wire logic [1:0] sink_mode,
    input wire logic pix_ready,
    input wire logic tx_valid,
    input wire logic tx_last,
    input wire logic [ccs_pkg::PIX_W-1:0] tx_data,
    output logic [ccs_pkg::PIX_W-1:0] pix_data,
    output logic pix_last,
    output logic pix_valid,
    output logic tx_ready,
    output int rx_words,
    output int rx_frames,
    output int rx_bad
);
    int idx;
    int pos;
    initial begin
        idx = 0;
        pos = 0;
        rx_bad = 0;
        pix_data = 32'h0;
        pix_last = 1'b0;
        pix_valid = 1'b0;
        tx_ready = 1'b1;
        rx_words = 0;
        rx_frames = 0;
    end
    // source: idle data toggles every cycle
    always @(posedge clk) begin
        if (start) begin
            pix_valid <= 1'b1;
            pix_data <= 32'h100;
            idx <= 1;
        end else if (pix_valid && pix_ready) begin
            pix_valid <= !pix_last;
            pix_data <= pix_last ? ~pix_data : pix_data + 32'h1;
            pix_last <= !pix_last && (idx == FLEN - 1);
            idx <= idx + 1;
        end else if (!pix_valid) begin
            pix_data <= ~pix_data;
        end
    end
    // sink: 0 ready, 1 every other cycle, 2 halted
    always @(posedge clk) begin
        tx_ready <= (sink_mode == 2'h0) || (sink_mode == 2'h1 && !tx_ready);
        if (tx_valid && tx_ready) begin
            rx_words <= rx_words + 1;
            rx_frames <= rx_frames + int'(tx_last);
            rx_bad <= rx_bad + int'(tx_data !== (32'h100 + pos));
            pos <= tx_last ? 0 : pos + 1;
        end
    end
endmodule // ccs_pix_model
`default_nettype wire

/* testbench.sv */
// self-checking bench for the capture and config store registers
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import ccs_pkg::*;
    logic clk = 0, rst_n = 0, wr = 0, rd = 0, start = 0;
    logic [REG_AW-1:0] addr = '0;
    logic [REG_DW-1:0] wdata = '0;
    logic [REG_DW-1:0] rdata;
    logic [PIX_W-1:0] pd, txd;
    logic pl, pv, pr, txl, txv, txr, cap;
    logic [FLD_W-1:0] fmt, mode;
    logic [1:0] smode = 2'h1;
    int rxw, rxf, rxb, mismatches = 0, tests_run = 0;
    initial begin
        forever #2 clk = ~clk;
    end
    ccs_regs_top u_dut (.CORE_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .PIX_DATA(pd), .PIX_LAST(pl),
        .PIX_VALID(pv), .PIX_READY(pr), .TX_DATA(txd), .TX_LAST(txl), .TX_VALID(txv),
        .TX_READY(txr), .CAPTURE_EN(cap), .VIDEO_FORMAT(fmt), .VIDEO_MODE(mode));
    ccs_pix_model u_src (.clk(clk), .start(start), .sink_mode(smode), .pix_ready(pr),
        .tx_valid(txv), .tx_last(txl), .pix_data(pd), .pix_last(pl), .pix_valid(pv),
        .tx_ready(txr), .rx_words(rxw), .rx_frames(rxf), .tx_data(txd), .rx_bad(rxb));
    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr_reg(logic [11:0] a, logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(logic [11:0] a, logic [31:0] e, bit now = 0);
        if (!now) @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk("rdata", e, rdata);
    endtask
    task automatic frame(int words, bit stall = 0);
        int f0 = rxf;
        int w0 = rxw;
        int b0 = rxb;
        @(posedge clk);
        start <= 1'b1;
        smode <= stall ? 2'h2 : 2'h1;
        @(posedge clk);
        start <= 1'b0;
        if (stall) begin
            repeat (20) @(posedge clk);
            @(negedge clk);
            chk("pix_ready", 32'h0, pr);
            @(posedge clk);
            smode <= 2'h1;
        end
        for (int i = 0; i < 300 && (pv || txv || i < 2); i++) @(posedge clk);
        @(negedge clk);
        chk("frames", words > 0, rxf - f0);
        chk("words", words, rxw - w0);
        chk("tx_data", 32'h0, rxb - b0);
    endtask
    task automatic t_reset();
        @(negedge clk);
        chk("capture", 32'h0, cap);
        chk("format", RST_FORMAT, fmt);
        rd_reg(OFF_CONT, 32'h0);
        rd_reg(OFF_SHOT, 32'h0);
        rd_reg(OFF_SAVE_CH, RST_SAVE_CH);
        rd_reg(OFF_LOAD_CH, RST_LOAD_CH);
        rd_reg(12'h7f0, 32'h0);
        rd_reg(OFF_STATUS, 32'h4);
    endtask
    task automatic t_fmt();
        for (int f = 0; f < 8; f++) begin
            wr_reg(OFF_FORMAT, f);
            @(negedge clk);
            chk("format", f, fmt);
            wr_reg(OFF_CONT, 32'h1);
            rd_reg(OFF_CONT, f == 0 || f == 7);
            wr_reg(OFF_CONT, 32'h0);
        end
        wr_reg(OFF_FORMAT, 32'h3);
        wr_reg(OFF_SHOT, 32'h1);
        frame(0);
        wr_reg(OFF_FORMAT, 32'h7);
    endtask
    task automatic t_shot();
        wr_reg(OFF_SHOT, 32'h1);
        frame(12, 1);
        rd_reg(OFF_SHOT, 32'h0);
        frame(0);
        wr_reg(OFF_SHOT, 32'hffff_0002);
        frame(0);
    endtask
    task automatic t_cont();
        wr_reg(OFF_CONT, 32'h1);
        @(posedge clk);
        @(negedge clk);
        chk("capture", 32'h1, cap);
        frame(12);
        frame(12);
        wr_reg(OFF_CONT, 32'h0);
        @(posedge clk);
        @(negedge clk);
        chk("capture", 32'h0, cap);
        frame(0);
    endtask
    task automatic t_store();
        wr_reg(OFF_MODE, 32'h5);
        rd_reg(OFF_MODE, 32'h5, 1);
        wr_reg(OFF_FORMAT, 32'h0);
        wr_reg(OFF_SAVE_CH, 32'h2);
        wr_reg(OFF_SAVE, 32'h1);
        rd_reg(OFF_SAVE, 32'h1, 1);
        rd_reg(OFF_SAVE, 32'h0);
        wr_reg(OFF_SAVE_CH, 32'h0);
        rd_reg(OFF_SAVE_CH, 32'h2);
        for (int c = 3; c >= 0; c -= 3) begin
            wr_reg(OFF_LOAD_CH, c);
            @(negedge clk);
            chk("format", RST_FORMAT, fmt);
            chk("mode", RST_MODE, mode);
        end
        wr_reg(OFF_LOAD_CH, 32'h2);
        rd_reg(OFF_LOAD_CH, 32'h2, 1);
        chk("mode", 32'h5, mode);
        chk("format", 32'h0, fmt);
        wr_reg(OFF_LOAD_CH, 32'h6);
        rd_reg(OFF_LOAD_CH, 32'h2);
        wr_reg(OFF_LOAD_CH, 32'h1);
        rd_reg(OFF_LOAD_CH, 32'h1);
    endtask
    task automatic finish_test();
        if (mismatches == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_fmt();
        t_shot();
        t_cont();
        t_store();
        finish_test();
    end
endmodule // testbench
`default_nettype wire
